// File: usb_identity_and_power_status.sv
// usb identity values and bus current indicator for a two channel bridge
// assumes usb core flags and the config memory loader run on ref_clk
`timescale 1ns/1ns
`default_nettype none
`include "usb_ident_regs.svh"
module usb_identity_and_power_status
#(
   parameter logic [15:0] DEF_VENDOR_ID = 16'h1234, // arbitrary value
   parameter logic [15:0] DEF_PRODUCT_ID = 16'h5678, // arbitrary value
   parameter logic [7:0] MEM_SIGNATURE = 8'ha5 // arbitrary value
)
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic usb_suspended,
   input wire logic usb_configured,
   input wire logic usb_bus_reset,
   input wire logic sda_strap,
   input wire logic scl_strap,
   input wire logic ld_wr,
   input wire logic [2:0] ld_addr,
   input wire logic [7:0] ld_data,
   input wire logic ld_done,
   input wire logic bus_current_unsafe_indicator_i,
   output logic bus_current_unsafe_indicator_o,
   output logic bus_current_unsafe_indicator_oe,
   output logic [15:0] vendor_id,
   output logic [15:0] product_id,
   output logic [7:0] cfg_attributes,
   output logic [7:0] cfg_max_power,
   output logic mem_valid,
   output logic ident_ready,
   output logic [3:0] num_configs,
   output logic [3:0] num_ctrl_ep,
   output logic [3:0] num_interfaces,
   output logic [3:0] num_bulk_in_ep,
   output logic [3:0] num_bulk_out_ep,
   output logic [3:0] num_intr_ep,
   output logic [7:0] if_class,
   output logic [7:0] if_subclass
);
   logic [1:0] rst_sync_ff;
   logic rst_n;
   logic [2:0] ind_sync_ff;
   logic [2:0] sda_sync_ff;
   logic [2:0] scl_sync_ff;
   usb_ident_pkg::load_state_t ld_state_ff, nxt_ld_state;
   usb_ident_pkg::pol_state_t pol_state_ff;
   logic [3:0] scan_cnt_ff;
   logic cap_vld_ff;
   logic [2:0] cap_addr_ff;
   logic [7:0] byte_ff [0:`MEM_WORDS-1];
   logic straps_high_ff;
   logic valid_ff;
   logic ready_ff;
   logic [8:0] samp_cnt_ff;
   logic pol_high_ff;
   logic ind_o_ff;
   logic [7:0] act_max_power;
   logic high_power;
   logic unsafe;
   logic ind_stable;
   logic samp_end;
   logic [7:0] sig_byte;
   cfg_mem_if mem ();

   // reset release through two flops, assertion stays asynchronous
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         rst_sync_ff <= 2'b00;
      else
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
   end
   assign rst_n = rst_sync_ff[1];

   // pin inputs pass three flops; only stages two and three are compared
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ind_sync_ff <= 3'h0;
         sda_sync_ff <= 3'h0;
         scl_sync_ff <= 3'h0;
      end
      else
      begin
         ind_sync_ff <= {ind_sync_ff[1:0], bus_current_unsafe_indicator_i};
         sda_sync_ff <= {sda_sync_ff[1:0], sda_strap};
         scl_sync_ff <= {scl_sync_ff[1:0], scl_strap};
      end
   end
   assign ind_stable = ind_sync_ff[1] == ind_sync_ff[2];

   cfg_byte_store u_store
   (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .mem(mem)
   );

   // loader writes straight into the store
   assign mem.wr_en = ld_wr;
   assign mem.wr_addr = ld_addr;
   assign mem.wr_data = ld_data;
   assign mem.rd_addr = scan_cnt_ff[2:0];

   // scan eight bytes; two extra counts (eight and nine) let byte seven land before the compare
   always_comb
   begin
      nxt_ld_state = ld_state_ff;
      unique case (ld_state_ff)
         usb_ident_pkg::LD_IDLE:
            if (ld_done)
               nxt_ld_state = usb_ident_pkg::LD_SCAN;
         usb_ident_pkg::LD_SCAN:
            if (scan_cnt_ff == 4'h9)
               nxt_ld_state = usb_ident_pkg::LD_DONE;
         usb_ident_pkg::LD_DONE:
            nxt_ld_state = usb_ident_pkg::LD_DONE;
         default:
            nxt_ld_state = usb_ident_pkg::LD_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ld_state_ff <= usb_ident_pkg::LD_IDLE;
         scan_cnt_ff <= 4'h0;
         cap_vld_ff <= 1'b0;
         cap_addr_ff <= 3'h0;
      end
      else
      begin
         ld_state_ff <= nxt_ld_state;
         cap_vld_ff <= (ld_state_ff == usb_ident_pkg::LD_SCAN) && !scan_cnt_ff[3];
         cap_addr_ff <= scan_cnt_ff[2:0];
         if (ld_state_ff == usb_ident_pkg::LD_SCAN && scan_cnt_ff != 4'h9)
            scan_cnt_ff <= scan_cnt_ff + 4'h1;
      end
   end

   // shadow copy, one entry per byte
   genvar gi;
   generate
      for (gi = 0; gi < `MEM_WORDS; gi++)
      begin : g_shadow
         always_ff @(posedge ref_clk or negedge rst_n)
         begin
            if (!rst_n)
               byte_ff[gi] <= 8'h00;
            else if (cap_vld_ff && cap_addr_ff == 3'(gi))
               byte_ff[gi] <= mem.rd_data;
         end
      end
   endgenerate

   // straps sampled every cycle while LD_IDLE, held from the start of the scan
   assign sig_byte = byte_ff[`MEM_SIG];
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         straps_high_ff <= 1'b0;
         valid_ff <= 1'b0;
         ready_ff <= 1'b0;
      end
      else
      begin
         if (ld_state_ff == usb_ident_pkg::LD_IDLE)
            straps_high_ff <= sda_sync_ff[2] && scl_sync_ff[2];
         if (ld_state_ff == usb_ident_pkg::LD_SCAN && scan_cnt_ff == 4'h9)
         begin
            valid_ff <= straps_high_ff && (sig_byte == MEM_SIGNATURE);
            ready_ff <= 1'b1;
         end
      end
   end

   // memory image wins only when validated
   assign act_max_power = valid_ff ? byte_ff[`MEM_MAXPWR] : `DEF_MAXPWR;
   assign high_power = act_max_power > `UNIT_LOAD_LIMIT;
   assign unsafe = usb_suspended || (high_power && !usb_configured);

   // indicator polarity: release pin, wait, then latch the settled strap
   assign samp_end = samp_cnt_ff == 9'(`STRAP_SAMPLE_CYC - 1);
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pol_state_ff <= usb_ident_pkg::PS_SAMPLE;
         samp_cnt_ff <= 9'h000;
         pol_high_ff <= 1'b1;
         ind_o_ff <= 1'b0;
      end
      else if (usb_bus_reset)
      begin
         pol_state_ff <= usb_ident_pkg::PS_SAMPLE;
         samp_cnt_ff <= 9'h000;
      end
      else if (pol_state_ff == usb_ident_pkg::PS_SAMPLE)
      begin
         if (!samp_end)
            samp_cnt_ff <= samp_cnt_ff + 9'h001;
         else if (ind_stable)
         begin
            pol_high_ff <= ind_sync_ff[2];
            pol_state_ff <= usb_ident_pkg::PS_RUN;
         end
      end
      else
         ind_o_ff <= unsafe ? pol_high_ff : !pol_high_ff;
   end
   // pin is only driven once the polarity is known
   assign bus_current_unsafe_indicator_o = ind_o_ff;
   assign bus_current_unsafe_indicator_oe = pol_state_ff == usb_ident_pkg::PS_RUN;

   // identity and descriptor shape outputs
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         vendor_id <= 16'h0000;
         product_id <= 16'h0000;
         cfg_attributes <= 8'h00;
         cfg_max_power <= 8'h00;
      end
      else
      begin
         vendor_id <= valid_ff ? {byte_ff[`MEM_VID_HI], byte_ff[`MEM_VID_LO]}
                               : DEF_VENDOR_ID;
         product_id <= valid_ff ? {byte_ff[`MEM_PID_HI], byte_ff[`MEM_PID_LO]}
                                : DEF_PRODUCT_ID;
         cfg_attributes <= valid_ff ? byte_ff[`MEM_ATTR] : `DEF_ATTR;
         cfg_max_power <= act_max_power;
      end
   end
   assign mem_valid = valid_ff;
   assign ident_ready = ready_ff;
   assign num_configs = `NUM_CONFIGS;
   assign num_ctrl_ep = `NUM_CTRL_EP;
   assign num_interfaces = 4'(`NUM_CHANNELS * `IF_PER_CHANNEL);
   assign num_bulk_in_ep = `NUM_CHANNELS;
   assign num_bulk_out_ep = `NUM_CHANNELS;
   assign num_intr_ep = `NUM_CHANNELS;
   assign if_class = `CDC_CLASS;
   assign if_subclass = `ACM_SUBCLASS;

   // checks
   unsafe_level_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (pol_state_ff == usb_ident_pkg::PS_RUN && $past(pol_state_ff == usb_ident_pkg::PS_RUN)
       && $past(unsafe)) |-> ind_o_ff == pol_high_ff) else $error("indicator not asserted");
   low_power_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (!high_power && !usb_suspended && pol_state_ff == usb_ident_pkg::PS_RUN) |=>
      (usb_bus_reset || $past(usb_bus_reset) || ind_o_ff != pol_high_ff))
      else $error("low power device asserted outside suspend");
   high_power_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (high_power && !usb_configured && !usb_bus_reset
       && pol_state_ff == usb_ident_pkg::PS_RUN) |=> ind_o_ff == pol_high_ff)
      else $error("unconfigured high power not asserted");
   release_safe_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (!unsafe && !usb_bus_reset && pol_state_ff == usb_ident_pkg::PS_RUN) |=>
      ind_o_ff == !pol_high_ff) else $error("indicator not released");
   resample_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      usb_bus_reset |=> !bus_current_unsafe_indicator_oe[*8])
      else $error("pin driven during strap sample");
   pol_latch_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (pol_state_ff == usb_ident_pkg::PS_SAMPLE && samp_end && ind_stable && !usb_bus_reset)
      |=> pol_high_ff == $past(ind_sync_ff[2])) else $error("polarity not latched");
   sig_check_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(ready_ff) |-> valid_ff == (straps_high_ff && sig_byte == MEM_SIGNATURE))
      else $error("signature check wrong");
   scan_time_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (ld_done && ld_state_ff == usb_ident_pkg::LD_IDLE) |-> ##[10:11] ready_ff)
      else $error("scan did not finish in time");
   vid_sel_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      rst_n |=> vendor_id == ($past(valid_ff) ? {$past(byte_ff[1]), $past(byte_ff[0])}
                                        : DEF_VENDOR_ID)) else $error("vendor id source");
   pid_sel_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (ready_ff && !valid_ff) |=> product_id == DEF_PRODUCT_ID) else $error("product id");
   thresh_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      high_power == ((valid_ff ? byte_ff[5] : 8'h2f) > 8'h32)) else $error("threshold");
   load_valid_c: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(valid_ff));
   suspend_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
      usb_suspended && bus_current_unsafe_indicator_oe);
   bus_reset_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
      usb_bus_reset ##[1:300] bus_current_unsafe_indicator_oe);
   high_pwr_c: cover property (@(posedge ref_clk) disable iff (!rst_n) high_power && ready_ff);
endmodule : usb_identity_and_power_status
`default_nettype wire

// File: usb_ident_regs.svh
// constants for the usb identity and bus current indicator logic
// assumes a 250 MHz ref_clk; included by bare name
`ifndef USB_IDENT_REGS_SVH
`define USB_IDENT_REGS_SVH
`define CLK_PERIOD_NS 4
`define STRAP_SAMPLE_NS 1000
`define STRAP_SAMPLE_CYC ((`STRAP_SAMPLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MEM_VID_LO 3'h0
`define MEM_VID_HI 3'h1
`define MEM_PID_LO 3'h2
`define MEM_PID_HI 3'h3
`define MEM_ATTR 3'h4
`define MEM_MAXPWR 3'h5
`define MEM_SIG 3'h7
`define MEM_WORDS 8
`define UNIT_LOAD_LIMIT 8'h32
`define DEF_ATTR 8'ha0
`define DEF_MAXPWR 8'h2f
`define NUM_CHANNELS 4'h2
`define NUM_CONFIGS 4'h1
`define NUM_CTRL_EP 4'h1
`define IF_PER_CHANNEL 4'h2
`define CDC_CLASS 8'h02
`define ACM_SUBCLASS 8'h02
`endif

// File: usb_ident_pkg.sv
// types for the usb identity and bus current indicator logic
// assumes nothing beyond the constants header
`default_nettype none
package usb_ident_pkg;
   typedef enum logic [1:0] {LD_IDLE = 2'b00, LD_SCAN = 2'b01, LD_DONE = 2'b10} load_state_t;
   typedef enum logic [0:0] {PS_SAMPLE = 1'b0, PS_RUN = 1'b1} pol_state_t;
endpackage : usb_ident_pkg
`default_nettype wire

// File: cfg_mem_if.sv
// carrier between the identity logic and its config byte store
// assumes one clock shared by both ends
`timescale 1ns/1ns
`default_nettype none
interface cfg_mem_if;
   logic wr_en;
   logic [2:0] wr_addr;
   logic [7:0] wr_data;
   logic [2:0] rd_addr;
   logic [7:0] rd_data;
   modport user (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
   modport store (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : cfg_mem_if
`default_nettype wire

// File: cfg_byte_store.sv
// eight byte store for the external config memory image
// assumes writes and reads on ref_clk; read data registered
`timescale 1ns/1ns
`default_nettype none
`include "usb_ident_regs.svh"
module cfg_byte_store
(
   input wire logic ref_clk,
   input wire logic rst_n,
   cfg_mem_if.store mem
);
   logic [7:0] mem_ff [0:`MEM_WORDS-1];
   logic [7:0] rd_ff;

   // storage has no reset; image is only trusted after a full load
   always_ff @(posedge ref_clk)
   begin
      if (mem.wr_en)
      begin
         mem_ff[mem.wr_addr] <= mem.wr_data;
      end
   end

   // registered read port
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         rd_ff <= 8'h00;
      else
         rd_ff <= mem_ff[mem.rd_addr];
   end

   assign mem.rd_data = rd_ff;
endmodule : cfg_byte_store
`default_nettype wire

// File: unused_placeholder_none.sv
// intentionally empty design file slot; holds nothing
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// File: cfg_mem_model.sv
// external config memory model: streams eight bytes into the loader port
// assumes ref_clk shared with the design; start is a one-cycle pulse
`timescale 1ns/1ns
`default_nettype none
module cfg_mem_model
#(
   parameter logic [15:0] MEM_VID = 16'h3c5a, // arbitrary value
   parameter logic [15:0] MEM_PID = 16'h7e42 // arbitrary value
)
(
   input wire logic ref_clk,
   input wire logic start,
   input wire logic [7:0] sig_byte,
   input wire logic [7:0] max_power,
   output logic ld_wr,
   output logic [2:0] ld_addr,
   output logic [7:0] ld_data,
   output logic ld_done
);
   logic [7:0] image [0:7];
   // image layout; product id kept even so host drivers match it
   always_comb
   begin
      image[0] = MEM_VID[7:0];
      image[1] = MEM_VID[15:8];
      image[2] = {MEM_PID[7:1], 1'b0};
      image[3] = MEM_PID[15:8];
      image[4] = 8'he0;
      image[5] = max_power;
      image[6] = 8'h00;
      image[7] = sig_byte;
   end
   initial
   begin
      ld_wr = 1'b0;
      ld_addr = 3'h0;
      ld_data = 8'h00;
      ld_done = 1'b0;
   end
   // one byte per cycle, then done; released bus shows inverted data
   always @(posedge ref_clk)
   begin
      if (start)
      begin
         for (int i = 0; i < 8; i++)
         begin
            #1 ld_wr = 1'b1;
            ld_addr = 3'(i);
            ld_data = image[i];
            @(posedge ref_clk);
         end
         #1 ld_wr = 1'b0;
         ld_data = ~ld_data;
         ld_done = 1'b1;
         @(posedge ref_clk);
         #1 ld_done = 1'b0;
      end
   end
endmodule : cfg_mem_model
`default_nettype wire

// File: usb_identity_and_power_status_tb.sv
// self-checking bench for identity values and bus current indicator
// assumes scl strap pulled high, sda strap driven; indicator pin has a pull
`timescale 1ns/1ns
`default_nettype none
module usb_identity_and_power_status_tb;
   localparam logic [15:0] VID = 16'h3c5a; // arbitrary value
   localparam logic [15:0] PID = 16'h7e42; // arbitrary value
   localparam logic [15:0] DEF_VID = 16'h1234; // arbitrary value
   localparam logic [15:0] DEF_PID = 16'h5678; // arbitrary value
   localparam logic [7:0] SIG = 8'ha5; // arbitrary value
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic susp = 1'b0;
   logic cfgd = 1'b0;
   logic bus_rst = 1'b0;
   logic pull_level = 1'b1;
   logic sda_lvl = 1'b1;
   logic mem_start = 1'b0;
   logic [7:0] sig_byte = SIG;
   logic [7:0] mem_power = 8'h33;
   logic ld_wr, ld_done, pin_o, pin_oe, mem_valid, ident_ready;
   logic [2:0] ld_addr;
   logic [7:0] ld_data, attr, max_pwr, if_class, if_sub;
   logic [15:0] vid, pid;
   logic [3:0] n_cfg, n_ctrl, n_if, n_bin, n_bout, n_intr;
   wire logic pin = pin_oe ? pin_o : pull_level;
   int n_mismatch = 0;
   int checks = 0;
   always #2 ref_clk = ~ref_clk;
   cfg_mem_model #(.MEM_VID(VID), .MEM_PID(PID)) mem (.ref_clk(ref_clk), .start(mem_start),
      .sig_byte(sig_byte), .max_power(mem_power), .ld_wr(ld_wr), .ld_addr(ld_addr),
      .ld_data(ld_data), .ld_done(ld_done));
   usb_identity_and_power_status #(.DEF_VENDOR_ID(DEF_VID), .DEF_PRODUCT_ID(DEF_PID),
      .MEM_SIGNATURE(SIG)) DUT (.ref_clk(ref_clk), .resetn(resetn), .usb_suspended(susp),
      .usb_configured(cfgd), .usb_bus_reset(bus_rst), .sda_strap(sda_lvl), .scl_strap(1'b1),
      .ld_wr(ld_wr), .ld_addr(ld_addr), .ld_data(ld_data), .ld_done(ld_done),
      .bus_current_unsafe_indicator_i(pin), .bus_current_unsafe_indicator_o(pin_o),
      .bus_current_unsafe_indicator_oe(pin_oe), .vendor_id(vid), .product_id(pid),
      .cfg_attributes(attr), .cfg_max_power(max_pwr), .mem_valid(mem_valid),
      .ident_ready(ident_ready), .num_configs(n_cfg), .num_ctrl_ep(n_ctrl),
      .num_interfaces(n_if), .num_bulk_in_ep(n_bin), .num_bulk_out_ep(n_bout),
      .num_intr_ep(n_intr), .if_class(if_class), .if_subclass(if_sub));
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic stop_test;
      if (n_mismatch == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : stop_test
   // reset held two cycles, then the internal copy settles
   task automatic reset_dut;
      #1 resetn = 1'b0;
      susp = 1'b0;
      cfgd = 1'b0;
      repeat (2) @(posedge ref_clk);
      #1 resetn = 1'b1;
      repeat (4) @(posedge ref_clk);
      #1;
   endtask : reset_dut
   task automatic load_mem(input logic [7:0] sig, input logic [7:0] pwr);
      int n;
      sig_byte = sig;
      mem_power = pwr;
      mem_start = 1'b1;
      @(posedge ref_clk);
      #1 mem_start = 1'b0;
      n = 0;
      while (ident_ready !== 1'b1 && n < 60)
      begin
         @(posedge ref_clk);
         #1 n++;
      end
      chk("ident_ready", 16'(ident_ready), 16'h1);
      repeat (2) @(posedge ref_clk);
      #1;
   endtask : load_mem
   // waits out strap sampling so the pin is driven again
   task automatic wait_run;
      int n;
      n = 0;
      while (pin_oe !== 1'b1 && n < 400)
      begin
         @(posedge ref_clk);
         #1 n++;
      end
      chk("oe_run", 16'(pin_oe), 16'h1);
   endtask : wait_run
   task automatic flags_chk(input logic s, input logic c, input logic exp);
      susp = s;
      cfgd = c;
      repeat (3) @(posedge ref_clk);
      #1 chk("indicator", 16'(pin_o), 16'(exp));
   endtask : flags_chk
   task automatic defaults_then_bad_sig;
      chk("vid_def", vid, DEF_VID);
      chk("pid_def", pid, DEF_PID);
      chk("pwr_def", 16'(max_pwr), 16'h002f);
      chk("attr_def", 16'(attr), 16'h00a0);
      chk("configs", {n_cfg, n_ctrl}, 16'h0011);
      chk("endpoints", {n_if, n_bin, n_bout, n_intr}, 16'h4222);
      chk("class", {if_class, if_sub}, 16'h0202);
      load_mem(~SIG, 8'h40);
      chk("valid_bad", 16'(mem_valid), 16'h0);
      chk("vid_bad", vid, DEF_VID);
      chk("pid_bad", pid, DEF_PID);
      chk("pwr_bad", 16'(max_pwr), 16'h002f);
   endtask : defaults_then_bad_sig
   // one strap low: good signature still ignored, defaults stay
   task automatic straps_low;
      sda_lvl = 1'b0;
      reset_dut();
      load_mem(SIG, 8'h40);
      chk("valid_strap", 16'(mem_valid), 16'h0);
      chk("vid_strap", vid, DEF_VID);
      chk("pwr_strap", 16'(max_pwr), 16'h002f);
      sda_lvl = 1'b1;
   endtask : straps_low
   // boundary 0x32 is still one unit load
   task automatic low_power_boundary;
      reset_dut();
      load_mem(SIG, 8'h32);
      chk("valid", 16'(mem_valid), 16'h1);
      chk("vid_mem", vid, VID);
      chk("pid_mem", pid, PID);
      chk("pwr_mem", 16'(max_pwr), 16'h0032);
      chk("attr_mem", 16'(attr), 16'h00e0);
      wait_run();
      flags_chk(1'b0, 1'b0, 1'b0);
      flags_chk(1'b1, 1'b0, 1'b1);
      flags_chk(1'b1, 1'b1, 1'b1);
      flags_chk(1'b0, 1'b1, 1'b0);
   endtask : low_power_boundary
   task automatic high_power;
      reset_dut();
      load_mem(SIG, 8'h33);
      chk("pwr_hi", 16'(max_pwr), 16'h0033);
      wait_run();
      flags_chk(1'b0, 1'b0, 1'b1);
      flags_chk(1'b1, 1'b1, 1'b1);
      flags_chk(1'b0, 1'b1, 1'b0);
      flags_chk(1'b0, 1'b0, 1'b1);
   endtask : high_power
   // bus reset resamples the pin; pull-down flips asserted level
   task automatic bus_reset_pull_down;
      pull_level = 1'b0;
      bus_rst = 1'b1;
      @(posedge ref_clk);
      #1 bus_rst = 1'b0;
      chk("oe_sample", 16'(pin_oe), 16'h0);
      wait_run();
      flags_chk(1'b1, 1'b1, 1'b0);
      flags_chk(1'b0, 1'b1, 1'b1);
      flags_chk(1'b0, 1'b0, 1'b0);
   endtask : bus_reset_pull_down
   // watchdog sized well past the ~860 cycles (about 3.5 us) the tests take
   initial
   begin
      #100000;
      n_mismatch++;
      stop_test();
   end
   initial
   begin
      reset_dut();
      defaults_then_bad_sig();
      straps_low();
      low_power_boundary();
      high_power();
      bus_reset_pull_down();
      stop_test();
   end
endmodule : usb_identity_and_power_status_tb
`default_nettype wire
